/* rtl/fsfr_top.sv */
module fsfr_top #(
	parameter int unsigned SYM_TICK_CYC = fsfr_pkg::SYM_TICK_CYC_DEF
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// register bus
	input wire fsfr_pkg::fsfr_axi_req_s axi_req_i,
	output fsfr_pkg::fsfr_axi_rsp_s axi_rsp_o,
	// receive symbols and demodulated bits
	input wire logic rx_sym_valid_i,
	input wire logic [1:0] rx_sym_i,
	input wire fsfr_pkg::fsfr_rxbit_s rx_bit_i,
	input wire logic end_of_burst_i,
	input wire logic crc_fail_i,
	input wire logic [3:0] crc_code_i,
	input wire logic [15:0] freq_err_i,
	input wire logic [15:0] rssi_i,
	// receive chain control
	output logic search_en_o,
	output logic demod_en_o,
	output logic rrc_en_o,
	output logic quad_chain_en_o,
	output logic event_o,
	// receive data out
	output logic rx_data_valid_o,
	output logic [3:0] rx_data_o,
	output logic voc_llr_valid_o,
	output logic [3:0] voc_llr_o,
	// transmit bit stream
	input wire logic tx_bit_req_i,
	input wire logic payload_bit_i,
	output logic payload_take_o,
	output logic tx_bit_valid_o,
	output logic tx_bit_o
);
	import fsfr_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_SEARCH, ST_DEMOD, ST_TX} fsfr_state_e;
	typedef enum logic [2:0] {TS_PRE, TS_SYNC, TS_RINFO, TS_SLOW, TS_PAY, TS_GUARD} fsfr_tseg_e;

	fsfr_state_e state_reg, state_next;
	fsfr_tseg_e tseg_reg, tseg_next;
	fsfr_axi_rsp_s rsp_reg;
	logic [31:0] mode_reg, config_reg;
	logic init_reg, late_reg, crc_reg;
	logic [3:0] err_reg;
	logic [FS1_BITS-1:0] sr_reg;
	logic [7:0] timer_reg;
	logic pend_reg, prior_reg;
	logic [15:0] tick_reg;
	logic [8:0] tcnt_reg;

	// register decode
	wire logic [1:0] op_mode = mode_reg[MODE_OP_LSB +: 2];
	wire logic quad_mode = mode_reg[MODE_QUAD_BIT];
	wire logic soft_en = mode_reg[MODE_SOFT_BIT];
	wire logic [1:0] ftype = mode_reg[MODE_FTYPE_LSB +: 2];
	wire logic late_en = config_reg[CFG_LATE_EN_BIT];
	wire logic keep_timer = config_reg[CFG_KEEP_TIMER_BIT];

	// write path: take address and data together, answer one cycle later
	wire logic wr_go = axi_req_i.awvalid & axi_req_i.wvalid & ~rsp_reg.awready & ~rsp_reg.bvalid;
	wire logic wr_mode = wr_go & (axi_req_i.awaddr == ADDR_MODE);
	wire logic wr_cfg = wr_go & (axi_req_i.awaddr == ADDR_CONFIG);
	wire logic wr_stat = wr_go & (axi_req_i.awaddr == ADDR_STATUS);
	wire logic wr_hit = wr_mode | wr_cfg | wr_stat | (axi_req_i.awaddr == ADDR_MEAS);
	wire logic [31:0] wmask = {{8{axi_req_i.wstrb[3]}}, {8{axi_req_i.wstrb[2]}},
		{8{axi_req_i.wstrb[1]}}, {8{axi_req_i.wstrb[0]}}};
	wire logic [31:0] w1c = wr_stat ? (axi_req_i.wdata & wmask) : 32'h0;
	wire logic rd_go = axi_req_i.arvalid & ~rsp_reg.arready & ~rsp_reg.rvalid;

	// read mux; measurements exist only on the quadrature path
	wire logic [31:0] stat_word = (32'(init_reg) << ST_INIT_BIT) | (32'(late_reg) << ST_LATE_BIT)
		| (32'(crc_reg) << ST_CRC_BIT) | (32'(err_reg) << ST_ERR_LSB)
		| (32'(state_reg == ST_DEMOD) << ST_DEMOD_BIT)
		| (32'(state_reg == ST_SEARCH) << ST_SEARCH_BIT);
	wire logic [31:0] meas_word = quad_mode ? {rssi_i, freq_err_i} : 32'h0;
	wire logic rd_mode = axi_req_i.araddr == ADDR_MODE;
	wire logic rd_cfg = axi_req_i.araddr == ADDR_CONFIG;
	wire logic rd_stat = axi_req_i.araddr == ADDR_STATUS;
	wire logic rd_meas = axi_req_i.araddr == ADDR_MEAS;
	wire logic rd_hit = rd_mode | rd_cfg | rd_stat | rd_meas;
	wire logic [31:0] rd_word = rd_mode ? mode_reg : rd_cfg ? config_reg
		: rd_stat ? stat_word : rd_meas ? meas_word : 32'h0;

	// bus handshake; rdata caught while address is still held
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rsp_reg <= '0;
		end else begin
			rsp_reg.awready <= wr_go;
			rsp_reg.wready <= wr_go;
			rsp_reg.bvalid <= rsp_reg.awready | (rsp_reg.bvalid & ~axi_req_i.bready);
			if (wr_go)
				rsp_reg.bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			rsp_reg.arready <= rd_go;
			rsp_reg.rvalid <= rsp_reg.arready | (rsp_reg.rvalid & ~axi_req_i.rready);
			if (rd_go) begin
				rsp_reg.rdata <= rd_word;
				rsp_reg.rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end
	assign axi_rsp_o = rsp_reg;

	// software-written control registers
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mode_reg <= 32'h0;
			config_reg <= 32'h0;
		end else begin
			if (wr_mode)
				mode_reg <= (mode_reg & ~wmask) | (axi_req_i.wdata & wmask);
			if (wr_cfg)
				config_reg <= (config_reg & ~wmask) | (axi_req_i.wdata & wmask);
		end
	end

	// symbol tick keeps the frame timer alive outside receive
	wire logic tick = tick_reg == 16'(SYM_TICK_CYC - 1);
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			tick_reg <= 16'h0;
		else
			tick_reg <= tick ? 16'h0 : tick_reg + 16'h1;
	end

	// sync search: exact compares on the symbol shift register
	wire logic in_rx = (state_reg == ST_SEARCH) | (state_reg == ST_DEMOD);
	wire logic sym_in = (state_reg == ST_SEARCH) & rx_sym_valid_i;
	wire logic [FS1_BITS-1:0] sr_shift = {sr_reg[FS1_BITS-3:0], rx_sym_i};
	wire logic fs1_hit = sr_shift == FS1_PAT;
	wire logic sw_hit = sr_shift[SYNC_BITS-1:0] == SYNC_WORD;
	wire logic timer_adv = in_rx ? rx_sym_valid_i : (keep_timer & prior_reg & tick);
	wire logic frame_due = timer_reg == FRAME_SYMS_M1;
	wire logic in_win = (timer_reg >= FRAME_SYMS_M1 - RESYNC_WIN) | (timer_reg < RESYNC_WIN);
	wire logic resync_ok = keep_timer & prior_reg & in_win;
	wire logic fs1_ev = sym_in & fs1_hit;
	wire logic fs2_ev = sym_in & ~fs1_hit & late_en & sw_hit
		& ((pend_reg & frame_due) | resync_ok);
	wire logic pend_start = sym_in & ~fs1_hit & late_en & sw_hit & ~fs2_ev;
	wire logic sync_ev = fs1_ev | fs2_ev;

	// operating state; exactly one mode holds at a time
	always_comb begin
		state_next = state_reg;
		unique case (op_mode)
			OP_RX: begin
				if (!in_rx)
					state_next = ST_SEARCH;
				else if (sync_ev)
					state_next = ST_DEMOD;
				else if ((state_reg == ST_DEMOD) && end_of_burst_i)
					state_next = ST_SEARCH;
			end
			OP_TX: state_next = ST_TX;
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// pattern history is flushed on every fresh search
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			sr_reg <= '0;
		else if (state_reg != ST_SEARCH)
			sr_reg <= '0;
		else if (sym_in)
			sr_reg <= sr_shift;
	end

	// frame timer, late-entry pending and prior-sync memory
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			timer_reg <= 8'h0;
			pend_reg <= 1'b0;
			prior_reg <= 1'b0;
		end else begin
			if (sync_ev || pend_start)
				timer_reg <= 8'h0;
			else if (timer_adv)
				timer_reg <= frame_due ? 8'h0 : timer_reg + 8'h1;
			if (pend_start)
				pend_reg <= 1'b1;
			else if (sync_ev || (sym_in && frame_due) || !in_rx)
				pend_reg <= 1'b0; // a missed second word restarts the pair
			if (sync_ev)
				prior_reg <= 1'b1;
			else if (!in_rx && !keep_timer)
				prior_reg <= 1'b0; // timer not kept, so old timing is void
		end
	end

	// sticky status; a set in the clearing cycle wins
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			init_reg <= 1'b0;
			late_reg <= 1'b0;
			crc_reg <= 1'b0;
			err_reg <= 4'h0;
		end else begin
			init_reg <= fs1_ev | (init_reg & ~w1c[ST_INIT_BIT]);
			late_reg <= fs2_ev | (late_reg & ~w1c[ST_LATE_BIT]);
			crc_reg <= crc_fail_i | (crc_reg & ~w1c[ST_CRC_BIT]);
			if (crc_fail_i)
				err_reg <= crc_code_i;
		end
	end

	// chain enables and event line
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			search_en_o <= 1'b0;
			demod_en_o <= 1'b0;
			rrc_en_o <= 1'b0;
			quad_chain_en_o <= 1'b0;
			event_o <= 1'b0;
		end else begin
			search_en_o <= state_next == ST_SEARCH;
			demod_en_o <= state_next == ST_DEMOD;
			rrc_en_o <= (state_next == ST_SEARCH) | (state_next == ST_DEMOD);
			quad_chain_en_o <= quad_mode & (op_mode == OP_RX);
			event_o <= crc_fail_i | (crc_reg & ~w1c[ST_CRC_BIT]);
		end
	end

	// received payload: hard or soft to host, soft to vocoder in voice frames only
	wire logic rx_take = (state_reg == ST_DEMOD) & rx_bit_i.valid;
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_data_valid_o <= 1'b0;
			rx_data_o <= 4'h0;
			voc_llr_valid_o <= 1'b0;
			voc_llr_o <= 4'h0;
		end else begin
			rx_data_valid_o <= rx_take;
			voc_llr_valid_o <= rx_take & (ftype == FT_VOICE);
			if (rx_take) begin
				rx_data_o <= soft_en ? rx_bit_i.llr : {3'h0, rx_bit_i.bit_val};
				voc_llr_o <= rx_bit_i.llr;
			end
		end
	end

	// transmit segment lengths per frame type
	function automatic logic [8:0] seg_len(input fsfr_tseg_e seg, input logic [1:0] ft);
		logic [8:0] len;
		len = LEN_RINFO;
		unique case (seg)
			TS_PRE: len = 9'(PRE_BITS);
			TS_SYNC: len = 9'(SYNC_BITS);
			TS_RINFO: len = LEN_RINFO;
			TS_SLOW: len = LEN_SLOW;
			TS_PAY: len = (ft == FT_DATA) ? LEN_LONG : (ft == FT_BURST) ? LEN_BURST
				: LEN_FAST_SHORT;
			TS_GUARD: len = LEN_GUARD;
		endcase
		return len;
	endfunction

	// next segment after the current one ends
	always_comb begin
		tseg_next = tseg_reg;
		unique case (tseg_reg)
			TS_PRE: tseg_next = TS_SYNC;
			TS_SYNC: tseg_next = TS_RINFO;
			TS_RINFO: tseg_next = (ftype == FT_VOICE) ? TS_SLOW : TS_PAY;
			TS_SLOW: tseg_next = TS_PAY;
			TS_PAY: tseg_next = (ftype == FT_BURST) ? TS_GUARD : TS_SYNC;
			TS_GUARD: tseg_next = TS_SYNC;
			default: tseg_next = TS_PRE;
		endcase
	end

	// transmit bit source: preamble and sync built here, fields from host
	wire logic tx_step = (state_reg == ST_TX) & tx_bit_req_i;
	wire logic seg_end = tcnt_reg == seg_len(tseg_reg, ftype) - 9'h1;
	wire logic from_host = (tseg_reg == TS_RINFO) | (tseg_reg == TS_SLOW) | (tseg_reg == TS_PAY);
	wire logic pre_bit = PRE_PAT[5'(PRE_BITS - 1) - tcnt_reg[4:0]];
	wire logic sync_bit = SYNC_WORD[5'(SYNC_BITS - 1) - tcnt_reg[4:0]];
	wire logic out_bit = (tseg_reg == TS_PRE) ? pre_bit : (tseg_reg == TS_SYNC) ? sync_bit
		: from_host ? payload_bit_i : 1'b0;

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tseg_reg <= TS_PRE;
			tcnt_reg <= 9'h0;
			tx_bit_valid_o <= 1'b0;
			tx_bit_o <= 1'b0;
			payload_take_o <= 1'b0;
		end else begin
			tx_bit_valid_o <= tx_step;
			payload_take_o <= tx_step & from_host;
			if (tx_step)
				tx_bit_o <= out_bit;
			if (state_reg != ST_TX) begin
				tseg_reg <= TS_PRE; // preamble only before the first frame
				tcnt_reg <= 9'h0;
			end else if (tx_step) begin
				tcnt_reg <= seg_end ? 9'h0 : tcnt_reg + 9'h1;
				if (seg_end)
					tseg_reg <= tseg_next;
			end
		end
	end
endmodule : fsfr_top

/* rtl/fsfr_pkg.sv */
package fsfr_pkg;
	// register map, byte addresses on the lite bus
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_CONFIG = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_MEAS = 8'h0c;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// mode register fields
	localparam int MODE_OP_LSB = 0;
	localparam int MODE_QUAD_BIT = 2;
	localparam int MODE_SOFT_BIT = 3;
	localparam int MODE_FTYPE_LSB = 4;
	localparam logic [1:0] OP_IDLE = 2'h0;
	localparam logic [1:0] OP_RX = 2'h1;
	localparam logic [1:0] OP_TX = 2'h2;
	localparam logic [1:0] FT_VOICE = 2'h0;
	localparam logic [1:0] FT_DATA = 2'h1;
	localparam logic [1:0] FT_BURST = 2'h2;

	// modem configuration fields
	localparam int CFG_LATE_EN_BIT = 8;
	localparam int CFG_KEEP_TIMER_BIT = 13;

	// status fields
	localparam int ST_INIT_BIT = 0;
	localparam int ST_LATE_BIT = 1;
	localparam int ST_CRC_BIT = 2;
	localparam int ST_ERR_LSB = 4;
	localparam int ST_DEMOD_BIT = 8;
	localparam int ST_SEARCH_BIT = 9;

	// sync patterns
	localparam int PRE_TAIL_BITS = 18;
	localparam int SYNC_BITS = 20;
	localparam int FS1_BITS = PRE_TAIL_BITS + SYNC_BITS;
	localparam logic [19:0] PRE_TAIL_WORD = 20'h375fd;
	localparam logic [19:0] SYNC_WORD = 20'hcdf59;
	localparam logic [FS1_BITS-1:0] FS1_PAT = {PRE_TAIL_WORD[PRE_TAIL_BITS-1:0], SYNC_WORD};
	localparam int PRE_BITS = 32;
	localparam logic [PRE_BITS-1:0] PRE_PAT = {12'h777, PRE_TAIL_WORD};

	// frame timing
	localparam int CLK_HZ = 100_000_000;
	localparam int BIT_RATE = 4800;
	localparam int SYM_RATE = 2400;
	localparam int FRAME_MS = 80;
	localparam int FRAME_SYMS = FRAME_MS * SYM_RATE / 1000;
	localparam logic [7:0] FRAME_SYMS_M1 = 8'(FRAME_SYMS - 1);
	localparam logic [7:0] RESYNC_WIN = 8'h02;
	localparam int SYM_TICK_CYC_DEF = CLK_HZ / SYM_RATE;

	// over-air field sizes and their host-side uncoded sizes
	localparam logic [8:0] LEN_RINFO = 9'd16;
	localparam logic [8:0] LEN_SLOW = 9'd60;
	localparam logic [8:0] LEN_FAST_SHORT = 9'd144;
	localparam logic [8:0] LEN_LONG = 9'd348;
	localparam logic [8:0] LEN_BURST = 9'd252;
	localparam logic [8:0] LEN_GUARD = 9'd96;
	localparam logic [8:0] LEN_TRAFFIC = 9'd72;
	localparam int UNC_RINFO = 7;
	localparam int UNC_SLOW = 8 + 18;
	localparam int UNC_FAST_SHORT = 80;
	localparam int UNC_LONG = 8 + 176;
	localparam int UNC_BURST = 252;
	localparam int UNC_TRAFFIC = 72;

	// lite bus carriers
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} fsfr_axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} fsfr_axi_rsp_s;

	// demodulated bit with its likelihood
	typedef struct packed {
		logic valid;
		logic bit_val;
		logic [3:0] llr;
	} fsfr_rxbit_s;
endpackage : fsfr_pkg

/* testbench/fsfr_chk_sva.sv */
module fsfr_chk (
	// watched clock, reset and inputs
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic rx_sym_valid_i,
	input wire fsfr_pkg::fsfr_rxbit_s rx_bit_i,
	input wire logic end_of_burst_i,
	input wire logic crc_fail_i,
	input wire logic tx_bit_req_i,
	// watched outputs
	input wire logic search_en_o,
	input wire logic demod_en_o,
	input wire logic event_o,
	input wire logic rx_data_valid_o,
	input wire logic voc_llr_valid_o,
	input wire logic [3:0] voc_llr_o,
	input wire logic payload_take_o,
	input wire logic tx_bit_valid_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import fsfr_pkg::*;

	// one domain, so one clock and one reset for every property
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);

	// search and demodulator never powered together
	excl_power_a: assert property (!(search_en_o && demod_en_o))
		else $error("search and demod both on");
	// demod only starts from a symbol seen while searching
	demod_start_a: assert property ($rose(demod_en_o) |-> $past(search_en_o) && $past(rx_sym_valid_i))
		else $error("demod started without a search symbol");
	// end of burst hands back to the search at once
	burst_end_a: assert property (demod_en_o && end_of_burst_i |=> !demod_en_o && search_en_o)
		else $error("end of burst did not restart search");
	// symbols in demod never drop back to the search
	sync_ignored_a: assert property (demod_en_o && rx_sym_valid_i && !end_of_burst_i |=> demod_en_o)
		else $error("demod left on a received symbol");
	crc_event_a: assert property (crc_fail_i |=> event_o)
		else $error("crc failure raised no event");
	// a transmitted bit answers a request and never overlaps receive
	tx_answer_a: assert property (tx_bit_valid_o |-> $past(tx_bit_req_i) && !search_en_o && !demod_en_o)
		else $error("transmit bit without request or while receiving");
	rx_demod_a: assert property (rx_data_valid_o |-> $past(demod_en_o) && $past(rx_bit_i.valid))
		else $error("receive data outside demod");
	voc_soft_a: assert property (voc_llr_valid_o |-> voc_llr_o == $past(rx_bit_i.llr))
		else $error("vocoder value is not the likelihood");
	host_take_a: assert property (payload_take_o |-> tx_bit_valid_o)
		else $error("host bit taken without a transmitted bit");

	// main scenarios
	sync_c: cover property ($rose(demod_en_o));
	tx_c: cover property (tx_bit_valid_o);
	voc_c: cover property (voc_llr_valid_o);
	evt_c: cover property (event_o && !crc_fail_i);
endmodule : fsfr_chk

bind fsfr_top fsfr_chk i_chk (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
	.rx_sym_valid_i(rx_sym_valid_i), .rx_bit_i(rx_bit_i), .end_of_burst_i(end_of_burst_i),
	.crc_fail_i(crc_fail_i), .tx_bit_req_i(tx_bit_req_i), .search_en_o(search_en_o),
	.demod_en_o(demod_en_o), .event_o(event_o), .rx_data_valid_o(rx_data_valid_o),
	.voc_llr_valid_o(voc_llr_valid_o), .voc_llr_o(voc_llr_o),
	.payload_take_o(payload_take_o), .tx_bit_valid_o(tx_bit_valid_o));

/* testbench/fsfr_sym_src.sv */
module fsfr_sym_src (
	// symbol strobe toward the sync search
	input wire logic clk_sys_i,
	output logic sym_valid_o,
	output logic [1:0] sym_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// quiet line at start
	initial begin
		sym_valid_o = 1'b0;
		sym_o = 2'h0;
	end

	// msb first, two bits a symbol; idle line inverted so a stale value never matches
	task automatic send(input logic [63:0] pat, input int nbits);
		for (int i = nbits - 1; i > 0; i -= 2) begin
			@(posedge clk_sys_i);
			sym_valid_o <= 1'b1;
			sym_o <= {pat[i], pat[i - 1]};
			@(posedge clk_sys_i);
			sym_valid_o <= 1'b0;
			sym_o <= ~{pat[i], pat[i - 1]};
			@(posedge clk_sys_i);
		end
	endtask : send
endmodule : fsfr_sym_src

/* testbench/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fsfr_pkg::*;

	// bench signals
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	fsfr_axi_req_s req = '0;
	fsfr_axi_rsp_s rsp;
	fsfr_rxbit_s rxb = '0;
	logic sym_v, eob = 1'b0, crc_f = 1'b0, tx_req = 1'b0;
	logic [1:0] sym;
	logic [3:0] crc_c = 4'h0;
	logic [15:0] ferr = 16'h0abc, rssi = 16'h1234;
	logic srch, dmd, rrc, quad, evt, rdv, vv, ptk, txv, txb;
	logic [3:0] rd, vl;
	logic [31:0] rdat;
	logic [1:0] rres;
	logic pbit = 1'b0;
	int err_count = 0, checks = 0, cyc = 0;

	// 100 MHz
	always #5 clk_sys_i = ~clk_sys_i;

	// short symbol tick keeps the run small
	fsfr_top #(.SYM_TICK_CYC(16)) i_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.axi_req_i(req), .axi_rsp_o(rsp), .rx_sym_valid_i(sym_v), .rx_sym_i(sym),
		.rx_bit_i(rxb), .end_of_burst_i(eob), .crc_fail_i(crc_f), .crc_code_i(crc_c),
		.freq_err_i(ferr), .rssi_i(rssi), .search_en_o(srch), .demod_en_o(dmd),
		.rrc_en_o(rrc), .quad_chain_en_o(quad), .event_o(evt), .rx_data_valid_o(rdv),
		.rx_data_o(rd), .voc_llr_valid_o(vv), .voc_llr_o(vl), .tx_bit_req_i(tx_req),
		.payload_bit_i(pbit), .payload_take_o(ptk), .tx_bit_valid_o(txv), .tx_bit_o(txb));
	fsfr_sym_src i_src (.clk_sys_i(clk_sys_i), .sym_valid_o(sym_v), .sym_o(sym));

	task automatic results;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			err_count++;
		end
	endtask : chk

	// lite write: address and data offered together, each dropped when taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		req.bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [7:0] a);
		@(posedge clk_sys_i);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		rdat = rsp.rdata;
		rres = rsp.rresp;
		req.rready <= 1'b0;
	endtask : axr

	// filler symbols between two lone sync words, one frame apart
	task automatic gap;
		repeat (FRAME_SYMS - 10) i_src.send(64'h0, 2);
	endtask : gap

	task automatic t_reset;
		axr(ADDR_STATUS);
		chk("status_rst", 32'h0, rdat);
		axr(8'h10);
		chk("unmapped_resp", 32'(RESP_SLVERR), 32'(rres));
		chk("idle_power", 32'h0, {srch, dmd});
	endtask : t_reset

	task automatic t_sync;
		axw(ADDR_CONFIG, 32'h100);
		axw(ADDR_MODE, 32'(OP_RX));
		@(negedge clk_sys_i);
		chk("search_rrc", 32'h3, {srch, rrc});
		i_src.send(64'(FS1_PAT ^ 38'h1), 38);
		axr(ADDR_STATUS);
		chk("near_miss", 32'h200, rdat & 32'h303);
		i_src.send(64'(FS1_PAT), 38);
		@(negedge clk_sys_i);
		chk("demod_on", 32'h2, {dmd, srch});
		axr(ADDR_STATUS);
		chk("initial_sync", 32'h101, rdat & 32'h303);
		// two lone sync words while demodulating must stay unseen
		i_src.send(64'(SYNC_WORD), 20);
		gap();
		i_src.send(64'(SYNC_WORD), 20);
		axr(ADDR_STATUS);
		chk("demod_quiet", 32'h101, rdat & 32'h303);
		@(posedge clk_sys_i);
		rxb <= '{valid: 1'b1, bit_val: 1'b1, llr: 4'ha};
		@(posedge clk_sys_i);
		rxb <= '0;
		@(negedge clk_sys_i);
		chk("rx_hard", 32'h11, {rdv, rd});
		chk("voc_soft", 32'h1a, {vv, vl});
		@(posedge clk_sys_i);
		eob <= 1'b1;
		@(posedge clk_sys_i);
		eob <= 1'b0;
		@(negedge clk_sys_i);
		chk("burst_end", 32'h1, {dmd, srch});
	endtask : t_sync

	task automatic t_late;
		i_src.send(64'h0, 20);
		i_src.send(64'(SYNC_WORD), 20);
		axr(ADDR_STATUS);
		chk("one_sync", 32'h200, rdat & 32'h302);
		gap();
		i_src.send(64'(SYNC_WORD), 20);
		axr(ADDR_STATUS);
		chk("late_entry", 32'h102, rdat & 32'h302);
	endtask : t_late

	task automatic t_crc;
		@(posedge clk_sys_i);
		crc_f <= 1'b1;
		crc_c <= 4'h5;
		@(posedge clk_sys_i);
		crc_f <= 1'b0;
		axr(ADDR_STATUS);
		chk("crc_code", 32'h54, rdat & 32'hf4);
		chk("event_set", 32'h1, evt);
		axw(ADDR_STATUS, 32'h4);
		@(negedge clk_sys_i);
		chk("event_clear", 32'h0, evt);
	endtask : t_crc

	task automatic t_quad;
		axw(ADDR_MODE, 32'h5);
		axr(ADDR_MEAS);
		chk("meas_quad", {rssi, ferr}, rdat);
		chk("quad_chain", 32'h1, quad);
		axw(ADDR_MODE, 32'(OP_RX));
		axr(ADDR_MEAS);
		chk("meas_ld", 32'h0, rdat);
	endtask : t_quad

	// kept timer: one sync word on the old frame timing is enough
	task automatic t_resync;
		axw(ADDR_CONFIG, 32'h2100);
		axw(ADDR_STATUS, 32'h2);
		@(posedge clk_sys_i);
		eob <= 1'b1;
		@(posedge clk_sys_i);
		eob <= 1'b0;
		gap();
		i_src.send(64'(SYNC_WORD), 20);
		axr(ADDR_STATUS);
		chk("resync", 32'h102, rdat & 32'h302);
		// soft output in a data frame; vocoder port left for the host to fill with silence
		axw(ADDR_MODE, 32'h19);
		@(posedge clk_sys_i);
		rxb <= '{valid: 1'b1, bit_val: 1'b0, llr: 4'h6};
		@(posedge clk_sys_i);
		rxb <= '0;
		@(negedge clk_sys_i);
		chk("rx_soft", 32'h16, {rdv, rd});
		chk("voc_data", 32'h0, vv);
	endtask : t_resync

	// back-to-back requests: a whole voice frame, then a burst frame's tail
	task automatic t_tx;
		logic [1:0] e;
		int ps, fr, bl;
		ps = PRE_BITS + SYNC_BITS;
		fr = ps + 16 + 60 + 144;
		bl = 16 + 252 + 96;
		axw(ADDR_MODE, 32'(OP_TX));
		@(posedge clk_sys_i);
		tx_req <= 1'b1;
		for (int k = 0; k < fr + SYNC_BITS; k++) begin
			@(posedge clk_sys_i);
			pbit <= ~pbit; // host bit flips each request, so bit k carries k parity
			if (k == fr + SYNC_BITS - 1) tx_req <= 1'b0;
			if (k < PRE_BITS) e = {1'b0, PRE_PAT[PRE_BITS - 1 - k]};
			else if (k < ps) e = {1'b0, SYNC_WORD[ps - 1 - k]};
			else if (k < fr) e = {1'b1, k[0]};
			else e = {1'b0, SYNC_WORD[fr + SYNC_BITS - 1 - k]};
			@(negedge clk_sys_i);
			chk("tx_bit", {1'b1, e}, {txv, ptk, txb});
		end
		chk("tx_no_rx", 32'h0, {srch, dmd});
		// switch to burst frames while still transmitting: info, burst data, guard, sync
		axw(ADDR_MODE, 32'h22);
		@(posedge clk_sys_i);
		tx_req <= 1'b1;
		for (int k = 0; k < bl + SYNC_BITS; k++) begin
			@(posedge clk_sys_i);
			pbit <= ~pbit;
			if (k == bl + SYNC_BITS - 1) tx_req <= 1'b0;
			if (k < 16 + 252) e = {1'b1, k[0]};
			else if (k < bl) e = 2'h0;
			else e = {1'b0, SYNC_WORD[bl + SYNC_BITS - 1 - k]};
			@(negedge clk_sys_i);
			chk("tx_burst", {1'b1, e}, {txv, ptk, txb});
		end
	endtask : t_tx

	// main sequence
	initial begin
		repeat (16) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		t_reset();
		t_sync();
		t_late();
		t_crc();
		t_quad();
		t_resync();
		t_tx();
		results();
	end

	// hang guard, well above the expected few thousand cycles
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			results();
		end
	end
endmodule : tb
